// file: hdl/relay_pkg.sv
// Shared constants and carrier types for the binary output relay logic.
package relay_pkg;

  // Width of a trigger-signal selector; selector value 0 means no signal.
  localparam int unsigned SEL_W        = 6;
  localparam int unsigned SLOTS        = 7;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;

  // Timing base: one tick each millisecond at 100 MHz.
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TIME_W        = 16;

  // Reset values.
  localparam logic        RST_CONTACT   = 1'b0;
  localparam logic        RST_LATCH     = 1'b0;

  // Operating mode of the relay coil.
  typedef enum logic [0:0] {
    MODE_WORKING = 1'b0,
    MODE_CLOSED  = 1'b1
  } op_mode_t;

  // Per-output configuration carried as one word.
  typedef struct packed {
    logic [SLOTS-1:0][SEL_W-1:0] sel;
    logic [SLOTS-1:0]            slot_invert;
    logic                        out_invert;
    op_mode_t                    mode;
    logic                        latched;
    logic [SEL_W-1:0]            ack_sel;
    logic [TIME_W-1:0]           hold_ms;
    logic [TIME_W-1:0]           off_delay_ms;
  } relay_cfg_t;

  // Acknowledge sources shared by all outputs.
  typedef struct packed {
    logic clear_key;
    logic group_output_ack;
    logic remote_ack;
    logic remote_permit;
  } ack_in_t;

endpackage : relay_pkg

// file: hdl/ms_timer.sv
// Down counter that reloads on an event and counts whole timing ticks.
`timescale 1ns/1ps
module ms_timer
  import relay_pkg::*;
#(
  parameter int unsigned W = TIME_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Control
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // Status
  output logic              busy
);

  logic [W-1:0] count;

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= value; // RULE18
    end else if (tick && count != '0) begin
      count <= count - W'(1); // RULE18
    end
  end

  always_comb begin
    busy = (count != '0);
  end

endmodule : ms_timer

// file: hdl/relay_output.sv
// Binary output relay: trigger OR, inversion, latching, acknowledge, hold and health contact.
//
// Contract
// RULE1 - Output state ORs up to seven triggers.
// RULE2 - Each trigger slot has its own invert.
// RULE3 - Empty slot reads as zero, invert ignored.
// RULE4 - Output invert complements the combined OR.
// RULE5 - No slots assigned forces combined state zero.
// RULE6 - Mode selects energise or de-energise on active.
// RULE7 - Unlatched contact follows combined state continuously.
// RULE8 - Latched contact holds until acknowledged.
// RULE9 - Latch clears only when all triggers inactive.
// RULE10 - Latch clears when all slots unassigned.
// RULE11 - Per-output acknowledge signal clears latch.
// RULE12 - Acknowledge waits for release-retention delay too.
// RULE13 - Each change held at least minimum hold.
// RULE14 - Latched state survives warm and cold restart.
// RULE15 - Group and remote acknowledge need permit.
// RULE16 - Local clear key acknowledges latched output.
// RULE17 - Health contact dropped until healthy start-up.
// RULE18 - Delays timed by tick-driven reloaded counters.
`timescale 1ns/1ps
module relay_output
  import relay_pkg::*;
#(
  parameter int unsigned NSIG     = 1 << SEL_W,
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // Restart without loss of latched state
  input  wire logic            restart,
  // Protection signals, indexed by selector; index 0 is unused
  input  wire logic [NSIG-1:0] prot_signals,
  // Configuration
  input  wire relay_cfg_t      cfg,
  // Acknowledge sources
  input  wire ack_in_t         ack_in,
  // Device health
  input  wire logic            boot_done,
  input  wire logic            internal_fault,
  // Relay drive
  output logic                 relay_coil,
  output logic                 contact_state,
  output logic                 latch_set,
  output logic                 health_contact
);

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger combination.

  logic [SLOTS-1:0] slot_val;
  logic             any_assigned;
  logic             raw_or;
  logic             combined;
  logic             trig_active;

  always_comb begin
    any_assigned = 1'b0;
    raw_or       = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (cfg.sel[i] == SEL_NONE) begin
        slot_val[i] = 1'b0; // RULE3
      end else begin
        slot_val[i]  = prot_signals[cfg.sel[i]] ^ cfg.slot_invert[i]; // RULE2
        any_assigned = 1'b1;
      end
      raw_or = raw_or | slot_val[i]; // RULE1
    end
    trig_active = raw_or;
    if (!any_assigned) begin
      combined = 1'b0; // RULE5
    end else begin
      combined = raw_or ^ cfg.out_invert; // RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timing tick and delay counters.

  // A divider of one would give a zero-width counter, so the width never drops below one bit.
  localparam int unsigned TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  logic [TW-1:0] tick_count;
  logic          tick;

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count == TW'(TICK_DIV - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1; // RULE18
    end else begin
      tick_count <= tick_count + TW'(1);
      tick       <= 1'b0;
    end
  end

  logic trig_prev;
  logic trig_fall;
  logic off_busy;

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_active;
    end
  end

  always_comb begin
    trig_fall = trig_prev && !trig_active;
  end

  ms_timer #(
    .W (TIME_W)
  ) u_off_delay (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .load  (trig_fall || trig_active),
    .value (cfg.off_delay_ms),
    .busy  (off_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Latching and acknowledge.

  logic prot_ack;
  logic ack_any;
  logic latch_clear;
  logic latch;

  always_comb begin
    prot_ack = (cfg.ack_sel != SEL_NONE) && cfg.latched && prot_signals[cfg.ack_sel]; // RULE11
    ack_any  = ack_in.clear_key // RULE16
             | prot_ack
             | (ack_in.remote_permit & (ack_in.group_output_ack | ack_in.remote_ack)); // RULE15
    latch_clear = !any_assigned // RULE10
                | (!cfg.latched)
                | (ack_any && !trig_active && !off_busy); // RULE9 RULE12
  end

  // The latch has no restart clear: only reset wipes it, restart leaves it.
  always_ff @(posedge clk) begin
    if (reset) begin
      latch <= RST_LATCH;
    end else if (combined && cfg.latched) begin
      latch <= 1'b1; // RULE8
    end else if (latch_clear) begin
      latch <= 1'b0; // RULE9
    end
  end

  logic target;

  always_comb begin
    if (cfg.latched) begin
      target = combined | latch; // RULE8 RULE14
    end else begin
      target = combined; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Minimum hold on every contact change.

  logic hold_busy;
  logic change;

  always_comb begin
    change = (target != contact_state) && !hold_busy;
  end

  ms_timer #(
    .W (TIME_W)
  ) u_hold (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .load  (change),
    .value (cfg.hold_ms),
    .busy  (hold_busy)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      contact_state <= RST_CONTACT;
    end else if (change) begin
      contact_state <= target; // RULE13
    end
  end

  logic target_q;

  // The coil follows the next contact value, so both outputs move on the same edge.
  always_comb begin
    target_q = (change) ? target : contact_state;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      relay_coil <= 1'b0;
    end else if (cfg.mode == MODE_CLOSED) begin
      relay_coil <= !target_q; // RULE6
    end else begin
      relay_coil <= target_q; // RULE6
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      latch_set <= 1'b0;
    end else begin
      latch_set <= latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Health contact.

  always_ff @(posedge clk) begin
    if (reset || restart) begin
      health_contact <= 1'b0; // RULE17
    end else begin
      health_contact <= boot_done && !internal_fault; // RULE17
    end
  end

endmodule : relay_output

// file: dv/relay_output_assertions.sv
// Port checker for the binary output relay.
`timescale 1ns/1ps
module relay_output_assertions
  import relay_pkg::*;
#(parameter int unsigned NSIG = 1 << SEL_W) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            restart,
  input wire logic [NSIG-1:0] prot_signals,
  input wire relay_cfg_t      cfg,
  input wire ack_in_t         ack_in,
  input wire logic            boot_done,
  input wire logic            internal_fault,
  input wire logic            relay_coil,
  input wire logic            contact_state,
  input wire logic            latch_set,
  input wire logic            health_contact
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic raw;
  logic hit;
  logic ack;
  always_comb begin
    raw = 1'b0;
    for (int i = 0; i < SLOTS; i++)
      if (cfg.sel[i] != SEL_NONE) raw = raw | (prot_signals[cfg.sel[i]] ^ cfg.slot_invert[i]);
    hit = raw;
    if (cfg.sel != '0) hit = hit ^ cfg.out_invert;
  end
  assign ack = ack_in.clear_key | (ack_in.remote_permit & (ack_in.group_output_ack | ack_in.remote_ack))
             | (cfg.ack_sel != SEL_NONE && prot_signals[cfg.ack_sel]);
  a_coil_mode: assert property (!$past(reset) && $stable(cfg.mode) |-> relay_coil == (contact_state ^ cfg.mode))
    else $error("coil polarity wrong");
  a_empty_zero: assert property ((cfg.sel == '0 && cfg.hold_ms == '0)[*3] |-> !contact_state)
    else $error("empty output not zero");
  a_follow_trig: assert property (!cfg.latched && !latch_set && cfg.hold_ms == '0 && !$past(reset)
    |=> contact_state == $past(hit))
    else $error("contact not following triggers");
  a_latch_keep: assert property ((cfg.latched && latch_set && contact_state
    && !ack && cfg.sel != '0)[*2] ##0 $stable(cfg) |=> contact_state)
    else $error("latched contact lost");
  a_set_wins: assert property (cfg.latched && hit && cfg.hold_ms == '0 && !$past(reset) |=> contact_state)
    else $error("active trigger not latched");
  a_ack_clears: assert property ((cfg.latched && ack && !hit && !raw && cfg.off_delay_ms == '0
    && cfg.hold_ms == '0)[*3] |-> !contact_state)
    else $error("acknowledge did not clear");
  a_off_delay: assert property ($fell(hit) && cfg.latched && latch_set && cfg.off_delay_ms > 16'h0001
    |=> contact_state [*8])
    else $error("cleared inside off delay");
  a_hold_min: assert property ($rose(contact_state) && cfg.hold_ms > 16'h0001 |-> contact_state [*8])
    else $error("hold time cut short");
  a_health_down: assert property (!boot_done || internal_fault || restart |=> !health_contact)
    else $error("health contact up while unhealthy");
endmodule : relay_output_assertions

// file: dv/tb.sv
// Self-checking bench for the binary output relay.
`timescale 1ns/1ps
module tb;
  import relay_pkg::*;
  logic        clk, reset, restart, boot_done, internal_fault;
  logic        relay_coil, contact_state, latch_set, health_contact;
  logic [63:0] prot;
  relay_cfg_t  cfg;
  ack_in_t     ack_in;
  int          errors;
  int          total_checks;
  ack_in_t     acks [3] = '{4'h8, 4'h5, 4'h3};
  relay_output #(.TICK_DIV(10)) u_relay_output (.clk(clk), .reset(reset), .restart(restart), .prot_signals(prot),
    .cfg(cfg), .ack_in(ack_in), .boot_done(boot_done), .internal_fault(internal_fault), .relay_coil(relay_coil),
    .contact_state(contact_state), .latch_set(latch_set), .health_contact(health_contact));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Samples one output after the edge settles, then realigns to the next edge.
  task automatic chk(input logic exp, input int k);
    logic [3:0] outs;
    #1;
    outs = {latch_set, health_contact, relay_coil, contact_state};
    total_checks++;
    if (outs[k] !== exp) begin
      errors++;
      $display("mismatch at %0t: output %0d expected %b", $time, k, exp);
    end
    @(posedge clk);
  endtask : chk
  // Waits a bounded number of cycles for the contact to reach a value; running out counts as a mismatch.
  task automatic wait_contact(input logic exp, input int limit);
    int n;
    n = 0;
    #1;
    while (contact_state !== exp && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    total_checks++;
    if (contact_state !== exp) begin
      errors++;
      $display("mismatch at %0t: contact did not reach %b", $time, exp);
    end
    @(posedge clk);
  endtask : wait_contact
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    total_checks = 0;
    reset = 1'b1;
    restart = 1'b0;
    prot = '0;
    cfg = '0;
    ack_in = '0;
    boot_done = 1'b0;
    internal_fault = 1'b0;
    wt(2);
    reset <= 1'b0;
    wt(3);
    chk(1'b0, 2);
    boot_done <= 1'b1;
    wt(3);
    chk(1'b1, 2);
    internal_fault <= 1'b1;
    cfg.out_invert <= 1'b1;
    cfg.slot_invert <= 7'h7F;
    wt(3);
    chk(1'b0, 2);
    chk(1'b0, 0);
    internal_fault <= 1'b0;
    cfg.slot_invert <= '0;
    cfg.out_invert <= 1'b0;
    for (int i = 0; i < SLOTS; i++) cfg.sel[i] <= SEL_W'(i + 1);
    for (int i = 1; i <= SLOTS; i++) begin
      prot <= 64'h1 << i;
      wt(2);
      chk(1'b1, 0);
    end
    chk(1'b1, 1);
    prot <= '0;
    cfg.slot_invert[3] <= 1'b1;
    wt(2);
    chk(1'b1, 0);
    cfg.out_invert <= 1'b1;
    cfg.mode <= MODE_CLOSED;
    wt(2);
    chk(1'b0, 0);
    chk(1'b1, 1);
    cfg.slot_invert <= '0;
    cfg.out_invert <= 1'b0;
    cfg.mode <= MODE_WORKING;
    cfg.latched <= 1'b1;
    foreach (acks[k]) begin
      prot <= 64'h2;
      wt(3);
      prot <= '0;
      ack_in <= 4'h4;
      restart <= 1'b1;
      wt(3);
      chk(1'b1, 0);
      chk(1'b1, 3);
      restart <= 1'b0;
      ack_in <= acks[k];
      wt(3);
      chk(1'b0, 0);
      ack_in <= '0;
    end
    prot <= 64'h202;
    cfg.ack_sel <= 6'h09;
    wt(3);
    chk(1'b1, 0);
    prot <= 64'h200;
    wt(3);
    chk(1'b0, 0);
    cfg.ack_sel <= SEL_NONE;
    prot <= 64'h2;
    wt(3);
    prot <= '0;
    cfg.latched <= 1'b0;
    wt(3);
    chk(1'b0, 0);
    cfg.latched <= 1'b1;
    prot <= 64'h2;
    wt(3);
    prot <= '0;
    cfg.sel <= '0;
    wt(3);
    chk(1'b0, 0);
    cfg.sel[0] <= 6'h01;
    cfg.off_delay_ms <= 16'h0002;
    prot <= 64'h2;
    wt(3);
    prot <= '0;
    ack_in <= 4'h8;
    wt(8);
    chk(1'b1, 0);
    wait_contact(1'b0, 40);
    reset <= 1'b1;
    ack_in <= '0;
    cfg.latched <= 1'b0;
    cfg.off_delay_ms <= '0;
    cfg.hold_ms <= 16'h0002;
    wt(2);
    reset <= 1'b0;
    wt(2);
    prot <= 64'h2;
    wt(2);
    prot <= '0;
    wt(8);
    chk(1'b1, 0);
    wait_contact(1'b0, 15);
    print_verdict();
  end
endmodule : tb
bind relay_output relay_output_assertions #(.NSIG(NSIG)) u_relay_output_assertions (.clk(clk), .reset(reset),
  .restart(restart), .prot_signals(prot_signals), .cfg(cfg), .ack_in(ack_in), .boot_done(boot_done),
  .internal_fault(internal_fault), .relay_coil(relay_coil), .contact_state(contact_state),
  .latch_set(latch_set), .health_contact(health_contact));
